// ===== hdl/pirq_consts.vh
// pirq_consts.vh: register offsets, bit positions, implemented-bit masks
// and reset values of the peripheral interrupt flag bank.
// assumes: included by bare name from the hdl/ design files.
`ifndef PIRQ_CONSTS_VH
`define PIRQ_CONSTS_VH

// register address width and offsets
`define PIRQ_ADDR_W          4
`define PIRQ_OFF_CONTROL     4'h0
`define PIRQ_OFF_ENABLE_TWO  4'h1
`define PIRQ_OFF_ENABLE_THR  4'h2
`define PIRQ_OFF_ENABLE_FOUR 4'h3
`define PIRQ_OFF_FLAGS_TWO   4'h4
`define PIRQ_OFF_FLAGS_THR   4'h5
`define PIRQ_OFF_FLAGS_FOUR  4'h6
`define PIRQ_OFF_STATUS      4'h7
`define PIRQ_OFF_MASK        4'h8

// global control bit positions
`define PIRQ_BIT_GLOBAL_EN   7
`define PIRQ_BIT_PERIPH_EN   6

// flags two bit positions
`define PIRQ_BIT_OSC_FAIL    7
`define PIRQ_BIT_CMP_TWO     6
`define PIRQ_BIT_CMP_ONE     5
`define PIRQ_BIT_EEPROM_DONE 4
`define PIRQ_BIT_SER1_COLL   3
`define PIRQ_BIT_LCD         2
`define PIRQ_BIT_CAPCOMP_TWO 0

// flags three bit positions
`define PIRQ_BIT_CAPCOMP_FIV 6
`define PIRQ_BIT_CAPCOMP_FOU 5
`define PIRQ_BIT_CAPCOMP_THR 4
`define PIRQ_BIT_TMR6_MATCH  3
`define PIRQ_BIT_TMR4_MATCH  1

// flags four bit positions
`define PIRQ_BIT_USART2_RX   5
`define PIRQ_BIT_USART2_TX   4
`define PIRQ_BIT_SER2_COLL   1
`define PIRQ_BIT_SER2_EVENT  0

// implemented-bit masks; other positions read zero
`define PIRQ_IMPL_FLAGS_TWO  8'hFD
`define PIRQ_IMPL_FLAGS_THR  8'h7A
`define PIRQ_IMPL_FLAGS_FOUR 8'h33
`define PIRQ_IMPL_ENABLE_TWO 8'hFF
`define PIRQ_IMPL_CONTROL    8'hC0
`define PIRQ_IMPL_STATUS     8'h07

// reset values
`define PIRQ_RST_BYTE        8'h00

`endif

// ===== hdl/pirq_flag_reg.v
// pirq_flag_reg.v: one 8-bit flag register, set by one-cycle events,
// written by software, unimplemented positions held at zero.
// assumes: events and writes come from logic on core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "pirq_consts.vh"

module pirq_flag_reg #(
    parameter [7:0] IMPL_MASK = 8'hFF
) (
    input  wire       core_clk,
    input  wire       sys_rst,
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    input  wire [7:0] evt_set,
    output reg  [7:0] flags
);

    reg [7:0] next_flags;

    // software write first, then events on top so a set is never lost
    always @*
    begin
        next_flags = wr_en ? wr_data : flags;
        next_flags = (next_flags | evt_set) & IMPL_MASK;
    end

    // all flags clear on every reset
    always @(posedge core_clk)
    begin
        if (sys_rst)
            flags <= `PIRQ_RST_BYTE;
        else
            flags <= next_flags;
    end

endmodule // pirq_flag_reg

`default_nettype wire

// ===== hdl/pirq_irq_status.v
// pirq_irq_status.v: sticky status bits, mask and one level interrupt.
// assumes: events are one-cycle pulses on core_clk; clear by writing one.
`timescale 1ns/100ps
`default_nettype none
`include "pirq_consts.vh"

module pirq_irq_status #(
    parameter N_EVT = 3
) (
    input  wire             core_clk,
    input  wire             sys_rst,
    input  wire [N_EVT-1:0] evt_pulse,
    input  wire             wr_status,
    input  wire             wr_mask,
    input  wire [N_EVT-1:0] wr_data,
    output reg  [N_EVT-1:0] status,
    output reg  [N_EVT-1:0] mask,
    output reg              irq_level
);

    wire [N_EVT-1:0] next_status;

    // write-one clears, a new event in the same cycle wins
    assign next_status = (status & ~({N_EVT{wr_status}} & wr_data))
                       | evt_pulse;

    // status, mask and registered interrupt level
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            status    <= {N_EVT{1'b0}};
            mask      <= {N_EVT{1'b0}};
            irq_level <= 1'b0;
        end
        else
        begin
            status    <= next_status;
            if (wr_mask)
                mask <= wr_data;
            irq_level <= |(status & mask);
        end
    end

endmodule // pirq_irq_status

`default_nettype wire

// ===== hdl/pirq_top.v
// pirq_top.v: peripheral interrupt flag registers two to four with their
// enables, the global control bits and the peripheral request output.
// assumes: event inputs are one-cycle pulses from peripherals on core_clk;
// software uses the plain register port, read data one cycle after strobe.
// an event held high keeps its flag set while it stays high.
// both outputs are registered levels for the core's interrupt logic.
//
// Behaviour
// - flags latch on their event regardless of any enable bit
// - flags read one while pending, zero otherwise; writable to clear
// - unimplemented flag positions always read zero
// - every implemented flag resets to zero on every reset
// - second register: osc, cmp two, cmp one, eeprom, ser1 coll, lcd, ccp2
// - third register: ccp five, four, three, timer six, timer four
// - fourth register: usart2 rx, usart2 tx, ser2 collision, ser2 event
`timescale 1ns/100ps
`default_nettype none
`include "pirq_consts.vh"

module pirq_top (
    // clock, reset and register port
    input  wire                   core_clk,
    input  wire                   sys_rst,
    input  wire [`PIRQ_ADDR_W-1:0] reg_addr,
    input  wire [7:0]             reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [7:0]             reg_rdata,
    // events of the second flag register
    input  wire                   osc_fail_evt,
    input  wire                   comparator_two_evt,
    input  wire                   comparator_one_evt,
    input  wire                   eeprom_write_done_evt,
    input  wire                   serial_one_collision_evt,
    input  wire                   lcd_evt,
    input  wire                   capcomp_two_evt,
    // events of the third flag register
    input  wire                   capcomp_five_evt,
    input  wire                   capcomp_four_evt,
    input  wire                   capcomp_three_evt,
    input  wire                   timer_six_match_evt,
    input  wire                   timer_four_match_evt,
    // events of the fourth flag register
    input  wire                   usart_two_rx_evt,
    input  wire                   usart_two_tx_evt,
    input  wire                   serial_two_collision_evt,
    input  wire                   serial_two_event_evt,
    // request and summary interrupt levels
    output reg                    periph_irq_request,
    output wire                   irq_out
);

    // true when a strobe addresses the given offset
    function addr_hit;
        input [`PIRQ_ADDR_W-1:0] addr;
        input [`PIRQ_ADDR_W-1:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // implemented mask of flag register n (0 = two, 1 = three, 2 = four)
    function [7:0] flag_mask;
        input integer n;
        begin
            case (n)
                0:       flag_mask = `PIRQ_IMPL_FLAGS_TWO;
                1:       flag_mask = `PIRQ_IMPL_FLAGS_THR;
                default: flag_mask = `PIRQ_IMPL_FLAGS_FOUR;
            endcase
        end
    endfunction

    // offset of flag register n
    function [`PIRQ_ADDR_W-1:0] flag_offset;
        input integer n;
        begin
            case (n)
                0:       flag_offset = `PIRQ_OFF_FLAGS_TWO;
                1:       flag_offset = `PIRQ_OFF_FLAGS_THR;
                default: flag_offset = `PIRQ_OFF_FLAGS_FOUR;
            endcase
        end
    endfunction

    // software-visible registers
    reg  [7:0]  global_irq_control;
    reg  [7:0]  periph_irq_enable_two;
    reg  [7:0]  periph_irq_enable_three;
    reg  [7:0]  periph_irq_enable_four;
    reg  [7:0]  next_rdata;

    // flag bank, its event map and the flattened views
    wire [7:0]  periph_irq_flags_two;
    wire [7:0]  periph_irq_flags_three;
    wire [7:0]  periph_irq_flags_four;
    wire [23:0] evt_set;
    wire [23:0] flags_all;
    wire [23:0] enables_all;

    // write strobes, one per register
    wire        wr_control;
    wire        wr_enable_two;
    wire        wr_enable_three;
    wire        wr_enable_four;
    wire        wr_status;
    wire        wr_mask;
    wire [2:0]  wr_flags;

    // summary status and request path
    wire [2:0]  new_pending;
    wire [2:0]  enabled_pending;
    wire [2:0]  sum_status;
    wire [2:0]  sum_mask;
    wire        global_irq_enable;
    wire        peripheral_irq_enable;
    wire        irq_gate;

    // write strobes decoded once; one write reaches one register only
    assign wr_control      =
        reg_wr & addr_hit(reg_addr, `PIRQ_OFF_CONTROL);
    assign wr_enable_two   =
        reg_wr & addr_hit(reg_addr, `PIRQ_OFF_ENABLE_TWO);
    assign wr_enable_three =
        reg_wr & addr_hit(reg_addr, `PIRQ_OFF_ENABLE_THR);
    assign wr_enable_four  =
        reg_wr & addr_hit(reg_addr, `PIRQ_OFF_ENABLE_FOUR);
    assign wr_status       =
        reg_wr & addr_hit(reg_addr, `PIRQ_OFF_STATUS);
    assign wr_mask         =
        reg_wr & addr_hit(reg_addr, `PIRQ_OFF_MASK);

    assign evt_set[`PIRQ_BIT_OSC_FAIL]    = osc_fail_evt;
    assign evt_set[`PIRQ_BIT_CMP_TWO]     = comparator_two_evt;
    assign evt_set[`PIRQ_BIT_CMP_ONE]     = comparator_one_evt;
    assign evt_set[`PIRQ_BIT_EEPROM_DONE] = eeprom_write_done_evt;
    assign evt_set[`PIRQ_BIT_SER1_COLL]   = serial_one_collision_evt;
    assign evt_set[`PIRQ_BIT_LCD]         = lcd_evt;
    assign evt_set[1]                     = 1'b0;
    assign evt_set[`PIRQ_BIT_CAPCOMP_TWO] = capcomp_two_evt;

    assign evt_set[8+7]                     = 1'b0;
    assign evt_set[8+`PIRQ_BIT_CAPCOMP_FIV] = capcomp_five_evt;
    assign evt_set[8+`PIRQ_BIT_CAPCOMP_FOU] = capcomp_four_evt;
    assign evt_set[8+`PIRQ_BIT_CAPCOMP_THR] = capcomp_three_evt;
    assign evt_set[8+`PIRQ_BIT_TMR6_MATCH]  = timer_six_match_evt;
    assign evt_set[8+2]                     = 1'b0;
    assign evt_set[8+`PIRQ_BIT_TMR4_MATCH]  = timer_four_match_evt;
    assign evt_set[8+0]                     = 1'b0;

    assign evt_set[16+7:16+6]              = 2'h0;
    assign evt_set[16+`PIRQ_BIT_USART2_RX] = usart_two_rx_evt;
    assign evt_set[16+`PIRQ_BIT_USART2_TX] = usart_two_tx_evt;
    assign evt_set[16+3:16+2]              = 2'h0;
    assign evt_set[16+`PIRQ_BIT_SER2_COLL] = serial_two_collision_evt;
    assign evt_set[16+`PIRQ_BIT_SER2_EVENT] = serial_two_event_evt;

    // the three flag registers, one instance each
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_flags
            // write strobe of this flag register
            assign wr_flags[g] = reg_wr & addr_hit(reg_addr, flag_offset(g));

            // set by event, enables not consulted
            // software write stores, so a pending flag can be cleared
            // cleared on reset inside the register
            pirq_flag_reg #(
                .IMPL_MASK (flag_mask(g))
            ) u_flag (
                .core_clk (core_clk),
                .sys_rst  (sys_rst),
                .wr_en    (wr_flags[g]),
                .wr_data  (reg_wdata),
                .evt_set  (evt_set[8*g+7:8*g]),
                .flags    (flags_all[8*g+7:8*g])
            );

            // an event arriving on a flag that is still clear raises a summary event
            assign new_pending[g] =
                |(evt_set[8*g+7:8*g] & ~flags_all[8*g+7:8*g]);

            // a set flag whose enable bit is set too
            assign enabled_pending[g] =
                |(flags_all[8*g+7:8*g] & enables_all[8*g+7:8*g]);
        end
    endgenerate

    // flag registers as software sees them
    assign periph_irq_flags_two   = flags_all[7:0];
    assign periph_irq_flags_three = flags_all[15:8];
    assign periph_irq_flags_four  = flags_all[23:16];

    // control register: only the two enable bits are kept
    always @(posedge core_clk)
    begin
        if (sys_rst)
            global_irq_control <= `PIRQ_RST_BYTE;
        else if (wr_control)
            global_irq_control <= reg_wdata & `PIRQ_IMPL_CONTROL;
    end

    // enable two: every position storable
    always @(posedge core_clk)
    begin
        if (sys_rst)
            periph_irq_enable_two <= `PIRQ_RST_BYTE;
        else if (wr_enable_two)
            periph_irq_enable_two <= reg_wdata & `PIRQ_IMPL_ENABLE_TWO;
    end

    // enable three: same holes as its flag register
    always @(posedge core_clk)
    begin
        if (sys_rst)
            periph_irq_enable_three <= `PIRQ_RST_BYTE;
        else if (wr_enable_three)
            periph_irq_enable_three <= reg_wdata & `PIRQ_IMPL_FLAGS_THR;
    end

    // enable four: same holes as its flag register
    always @(posedge core_clk)
    begin
        if (sys_rst)
            periph_irq_enable_four <= `PIRQ_RST_BYTE;
        else if (wr_enable_four)
            periph_irq_enable_four <= reg_wdata & `PIRQ_IMPL_FLAGS_FOUR;
    end

    // control bits, their joint gate and the flattened enable view
    assign global_irq_enable     = global_irq_control[`PIRQ_BIT_GLOBAL_EN];
    assign peripheral_irq_enable = global_irq_control[`PIRQ_BIT_PERIPH_EN];
    assign irq_gate              = global_irq_enable & peripheral_irq_enable;
    assign enables_all = {periph_irq_enable_four,
                          periph_irq_enable_three,
                          periph_irq_enable_two};

    // request from flag and enable, gated by both control bits
    always @(posedge core_clk)
    begin
        if (sys_rst)
            periph_irq_request <= 1'b0;
        else
            periph_irq_request <= (|enabled_pending) & irq_gate;
    end

    // summary status: one sticky bit per flag register
    pirq_irq_status #(
        .N_EVT (3)
    ) u_status (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .evt_pulse (new_pending),
        .wr_status (wr_status),
        .wr_mask   (wr_mask),
        .wr_data   (reg_wdata[2:0]),
        .status    (sum_status),
        .mask      (sum_mask),
        .irq_level (irq_out)
    );

    // read multiplexer; unmapped offsets read zero
    always @*
    begin
        case (reg_addr)
            `PIRQ_OFF_CONTROL:     next_rdata = global_irq_control;
            `PIRQ_OFF_ENABLE_TWO:  next_rdata = periph_irq_enable_two;
            `PIRQ_OFF_ENABLE_THR:  next_rdata = periph_irq_enable_three;
            `PIRQ_OFF_ENABLE_FOUR: next_rdata = periph_irq_enable_four;
            `PIRQ_OFF_FLAGS_TWO:   next_rdata = periph_irq_flags_two;
            `PIRQ_OFF_FLAGS_THR:   next_rdata = periph_irq_flags_three;
            `PIRQ_OFF_FLAGS_FOUR:  next_rdata = periph_irq_flags_four;
            // summary status and mask in the low three bits
            `PIRQ_OFF_STATUS:      next_rdata = {5'h00, sum_status};
            `PIRQ_OFF_MASK:        next_rdata = {5'h00, sum_mask};
            default:               next_rdata = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the read strobe
    always @(posedge core_clk)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 8'h00;
    end

endmodule // pirq_top

`default_nettype wire

// ===== tb/pirq_props.sv
// pirq_props.sv: port-level checks of the peripheral interrupt flag bank.
// assumes: bound to pirq_top; one clock, synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
`include "pirq_consts.vh"

module pirq_props (
    input wire logic                    core_clk,
    input wire logic                    sys_rst,
    input wire logic [`PIRQ_ADDR_W-1:0] reg_addr,
    input wire logic [7:0]              reg_wdata,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [7:0]              reg_rdata,
    input wire logic                    lcd_evt,
    input wire logic                    timer_six_match_evt,
    input wire logic                    usart_two_rx_evt,
    input wire logic                    periph_irq_request,
    input wire logic                    irq_out
);
    // every check runs on the core clock; all but AST_RST_OUT rest during reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // read port and unimplemented positions
    AST_RD_IDLE: assert property (
        !reg_rd |=> reg_rdata == 8'h00) else $error("stray read data");
    AST_F2_UNIMPL: assert property (
        reg_rd && reg_addr == `PIRQ_OFF_FLAGS_TWO |=> reg_rdata[1] == 1'b0)
        else $error("flags two bit 1 not zero");
    AST_F3_UNIMPL: assert property (
        reg_rd && reg_addr == `PIRQ_OFF_FLAGS_THR
        |=> (reg_rdata & 8'h85) == 8'h00) else $error("flags three hole set");
    AST_F4_UNIMPL: assert property (
        reg_rd && reg_addr == `PIRQ_OFF_FLAGS_FOUR
        |=> (reg_rdata & 8'hCC) == 8'h00) else $error("flags four hole set");
    // events latch whatever the enables hold
    AST_LCD_SET: assert property (
        lcd_evt ##1 (reg_rd && reg_addr == `PIRQ_OFF_FLAGS_TWO)
        |=> reg_rdata[`PIRQ_BIT_LCD]) else $error("lcd flag missed");
    AST_T6_SET: assert property (
        timer_six_match_evt ##1 !reg_wr [*2] ##1
        (reg_rd && reg_addr == `PIRQ_OFF_FLAGS_THR)
        |=> reg_rdata[`PIRQ_BIT_TMR6_MATCH]) else $error("timer six missed");
    AST_RX_SET: assert property (
        usart_two_rx_evt ##1 !reg_wr [*4] ##1
        (reg_rd && reg_addr == `PIRQ_OFF_FLAGS_FOUR)
        |=> reg_rdata[`PIRQ_BIT_USART2_RX]) else $error("usart rx missed");
    // request and interrupt levels drop only after software writes or a reset
    AST_REQ_FALL: assert property (
        $fell(periph_irq_request) |-> $past(reg_wr, 2))
        else $error("request fell with no write");
    AST_REQ_GATE: assert property (
        reg_wr && reg_addr == `PIRQ_OFF_CONTROL && !reg_wdata[7]
        |=> ##1 !periph_irq_request) else $error("request not gated");
    AST_IRQ_FALL: assert property (
        $fell(irq_out) |-> $past(reg_wr, 2)) else $error("irq fell alone");
    AST_RST_OUT: assert property (disable iff (1'b0)
        sys_rst |=> reg_rdata == 8'h00 && !periph_irq_request && !irq_out)
        else $error("outputs not cleared by reset");
endmodule // pirq_props
`default_nettype wire

// ===== tb/pirq_periph_model.sv
// pirq_periph_model.sv: peripherals raising one-cycle event conditions.
// assumes: bench asks for a set of events for one cycle on core_clk.
`timescale 1ns/100ps
`default_nettype none

module pirq_periph_model (
    input  wire logic        core_clk,
    input  wire logic [23:0] fire,
    output var  logic [23:0] evt
);
    // launch each requested condition as a pulse after the clock edge
    initial evt = 24'h000000;
    always @(posedge core_clk)
    begin
        evt <= fire;
    end
endmodule // pirq_periph_model
`default_nettype wire

// ===== tb/tb_top.sv
// tb_top.sv: self-checking bench of the peripheral interrupt flag bank.
// assumes: pirq_top, pirq_props and pirq_periph_model compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "pirq_consts.vh"

module tb_top;
    logic        core_clk   = 1'b0;
    logic        sys_rst    = 1'b1;
    logic [3:0]  reg_addr   = 4'h0;
    logic [7:0]  reg_wdata  = 8'h00;
    logic        reg_wr     = 1'b0;
    logic        reg_rd     = 1'b0;
    logic [23:0] fire       = 24'h000000;
    logic [31:0] seed       = 32'h00000060;
    logic [23:0] v;
    logic [7:0]  d;
    logic [7:0]  impl [3]   = '{`PIRQ_IMPL_FLAGS_TWO, `PIRQ_IMPL_FLAGS_THR,
                                `PIRQ_IMPL_FLAGS_FOUR};
    int          n_errors   = 0;
    int          num_checks = 0;
    wire logic [7:0]  reg_rdata;
    wire logic [23:0] evt;
    wire logic        req;
    wire logic        irq_out;

    // clock, peripherals and the block
    always #2.5 core_clk = ~core_clk;
    pirq_periph_model i_per (.core_clk(core_clk), .fire(fire), .evt(evt));
    pirq_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_fail_evt(evt[7]),
        .comparator_two_evt(evt[6]), .comparator_one_evt(evt[5]),
        .eeprom_write_done_evt(evt[4]), .serial_one_collision_evt(evt[3]),
        .lcd_evt(evt[2]), .capcomp_two_evt(evt[0]),
        .capcomp_five_evt(evt[14]), .capcomp_four_evt(evt[13]),
        .capcomp_three_evt(evt[12]), .timer_six_match_evt(evt[11]),
        .timer_four_match_evt(evt[9]), .usart_two_rx_evt(evt[21]),
        .usart_two_tx_evt(evt[20]), .serial_two_collision_evt(evt[17]),
        .serial_two_event_evt(evt[16]), .periph_irq_request(req),
        .irq_out(irq_out));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // summary bits: which flag register got a new flag
    function automatic logic [2:0] st(input logic [23:0] x);
        return {|(x[23:16] & impl[2]), |(x[15:8] & impl[1]),
                |(x[7:0] & impl[0])};
    endfunction

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] x);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= x;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        chk8(reg_rdata, e);
    endtask
    task automatic pulse(input logic [23:0] x);
        @(posedge core_clk);
        fire <= x;
        @(posedge core_clk);
        fire <= 24'h000000;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic zero_scan;
        for (int a = 0; a < 16; a++)
            rdc(a[3:0], 8'h00);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        zero_scan;
        $display("test reset done");
        for (int i = 0; i < 3; i++)
        begin
            wr(`PIRQ_OFF_FLAGS_TWO + i[3:0], 8'hFF);
            rdc(`PIRQ_OFF_FLAGS_TWO + i[3:0], impl[i]);
            wr(`PIRQ_OFF_FLAGS_TWO + i[3:0], 8'h00);
            rdc(`PIRQ_OFF_FLAGS_TWO + i[3:0], 8'h00);
        end
        wr(`PIRQ_OFF_STATUS, 8'h07);
        wr(`PIRQ_OFF_MASK, 8'h07);
        $display("test access done");
        for (int k = 0; k < 40; k++)
        begin
            void'(xs());
            v = (k == 0) ? 24'hFFFFFF : seed[23:0];
            pulse(v);
            for (int i = 0; i < 3; i++)
                rdc(`PIRQ_OFF_FLAGS_TWO + i[3:0], v[8*i +: 8] & impl[i]);
            chkb(irq_out, st(v) != 3'h0);
            rdc(`PIRQ_OFF_STATUS, {5'h00, st(v)});
            chkb(req, 1'b0);
            for (int i = 0; i < 3; i++)
                wr(`PIRQ_OFF_FLAGS_TWO + i[3:0], 8'h00);
            wr(`PIRQ_OFF_STATUS, 8'h07);
        end
        $display("test events done");
        // stale flags cleared before the source is enabled
        wr(`PIRQ_OFF_FLAGS_TWO, 8'h00);
        wr(`PIRQ_OFF_MASK, 8'h00);
        wr(`PIRQ_OFF_ENABLE_TWO, 8'h04);
        wr(`PIRQ_OFF_CONTROL, 8'hC0);
        pulse(24'h000004);
        settle(2);
        chkb(req, 1'b1);
        chkb(irq_out, 1'b0);
        for (int c = 0; c < 4; c++)
        begin
            wr(`PIRQ_OFF_CONTROL, {c[1:0], 6'h00});
            settle(1);
            chkb(req, c == 3);
        end
        wr(`PIRQ_OFF_FLAGS_TWO, 8'h00);
        pulse(24'h000001);
        settle(2);
        chkb(req, 1'b0);
        wr(`PIRQ_OFF_MASK, 8'h01);
        settle(1);
        chkb(irq_out, 1'b1);
        wr(`PIRQ_OFF_STATUS, 8'h01);
        settle(1);
        chkb(irq_out, 1'b0);
        $display("test request done");
        // an event and a clearing write in one cycle: the set wins
        @(posedge core_clk);
        fire <= 24'h000080;
        @(posedge core_clk);
        fire      <= 24'h000000;
        reg_addr  <= `PIRQ_OFF_FLAGS_TWO;
        reg_wdata <= 8'h00;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        rdc(`PIRQ_OFF_FLAGS_TWO, 8'h80);
        // enables of the third and fourth registers keep the flag holes; the fourth drives the request
        wr(`PIRQ_OFF_ENABLE_THR, 8'hFF);
        rdc(`PIRQ_OFF_ENABLE_THR, `PIRQ_IMPL_FLAGS_THR);
        wr(`PIRQ_OFF_ENABLE_FOUR, 8'hFF);
        rdc(`PIRQ_OFF_ENABLE_FOUR, `PIRQ_IMPL_FLAGS_FOUR);
        chkb(req, 1'b0);
        pulse(24'h200000);
        settle(2);
        chkb(req, 1'b1);
        $display("test corner done");
        pulse(24'hFFFFFF);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        zero_scan;
        chkb(req, 1'b0);
        $display("test mid reset done");
        final_report;
    end

    // watchdog against a hung sequence
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        $display("Error %0t: watchdog expired", $time);
        final_report;
    end
endmodule // tb_top

bind pirq_top pirq_props i_props (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lcd_evt(lcd_evt),
    .timer_six_match_evt(timer_six_match_evt),
    .usart_two_rx_evt(usart_two_rx_evt),
    .periph_irq_request(periph_irq_request), .irq_out(irq_out));
`default_nettype wire
